// File: core/rso_defines.vh
// Functional notes
// [RULE_01] Rotate right through carry, only carry changes.
// [RULE_02] Register index 0-127; destination bit selects target.
// [RULE_03] Register plus inverted working register plus carry.
// [RULE_04] Immediate form always writes working register.
// [RULE_05] Special page read copies to working register.
// [RULE_06] Halt clears watchdog, sets expiry, clears power-down.
// [RULE_07] Every operation completes in one cycle.
`ifndef RSO_DEFINES_VH
`define RSO_DEFINES_VH
`define RSO_OP_NONE 3'h0
`define RSO_OP_ROTATE 3'h1
`define RSO_OP_SUB_REG 3'h2
`define RSO_OP_SUB_IMM 3'h3
`define RSO_OP_SPECIAL 3'h4
`define RSO_OP_HALT 3'h5
`define RSO_ACC_RESET 8'h00
`define RSO_CARRY_RESET 1'b0
`define RSO_EXPIRY_RESET 1'b1
`define RSO_PDOWN_RESET 1'b1
`define RSO_HALF_RESET 1'b0
`define RSO_ZERO_RESET 1'b0
`define RSO_PULSE_RESET 1'b0
`define RSO_HALT_RESET 1'b0
`define RSO_WR_INDEX_RESET 7'h00
`define RSO_WR_DATA_RESET 8'h00
`endif

// File: core/rso_adder.v
`timescale 1ns/100ps
`default_nettype none
// Computes a + ~b + cin with nibble and byte carries.
module rso_adder (
	input wire [7:0] a_i,
	input wire [7:0] b_i,
	input wire cin_i,
	output wire [7:0] sum_o,
	output wire half_o,
	output wire carry_o
);
	wire [4:0] low;
	wire [4:0] high;
	assign low = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + {4'h0, cin_i};
	assign high = {1'b0, a_i[7:4]} + {1'b0, ~b_i[7:4]} + {4'h0, low[4]};
	assign sum_o = {high[3:0], low[3:0]};
	assign half_o = low[4];
	assign carry_o = high[4];
endmodule // rso_adder
`default_nettype wire

// File: core/rso_alu.v
`timescale 1ns/100ps
`default_nettype none
`include "rso_defines.vh"
module rso_alu (
	input wire core_clk_i,
	input wire reset_i,
	input wire clk_en_i,
	input wire op_valid_i,
	input wire [2:0] op_code_i,
	input wire [6:0] reg_index_i,
	input wire dest_reg_i,
	input wire [7:0] reg_data_i,
	input wire [7:0] imm_data_i,
	input wire [4:0] special_index_i,
	input wire [7:0] special_data_i,
	output wire [7:0] working_register_o,
	output wire carry_flag_o,
	output wire half_carry_flag_o,
	output wire zero_flag_o,
	output wire watchdog_expiry_flag_o,
	output wire power_down_flag_o,
	output wire reg_write_o,
	output wire [6:0] reg_write_index_o,
	output wire [7:0] reg_write_data_o,
	output wire watchdog_clear_o,
	output wire halt_o,
	output wire [6:0] reg_read_index_o,
	output wire [4:0] special_read_index_o
);
	////////////////////////////////////////////////////////////////////////
	// Register state and its next values.

	reg [7:0] acc_q;
	reg [7:0] acc_d;
	reg carry_q;
	reg carry_d;
	reg half_q;
	reg half_d;
	reg zero_q;
	reg zero_d;
	reg expiry_q;
	reg expiry_d;
	reg pdown_q;
	reg pdown_d;
	reg wr_q;
	reg wr_d;
	reg [6:0] wr_index_q;
	reg [6:0] wr_index_d;
	reg [7:0] wr_data_q;
	reg [7:0] wr_data_d;
	reg wd_clear_q;
	reg wd_clear_d;
	reg halt_q;
	reg halt_d;
	wire [7:0] add_a;
	wire [7:0] sum;
	wire half;
	wire carry;
	wire exec_op;
	wire to_reg;
	wire is_arith;
	wire is_rotate;
	wire is_halt;
	reg [7:0] result;

	////////////////////////////////////////////////////////////////////////
	// Decode helpers shared by the datapath and the next-state logic.

	// True for the operations that retire a result; none, halt and the
	// two unused codes leave the datapath registers alone.
	function f_is_exec(input [2:0] op);
		case (op)
			`RSO_OP_ROTATE: f_is_exec = 1'b1;
			`RSO_OP_SUB_REG: f_is_exec = 1'b1;
			`RSO_OP_SUB_IMM: f_is_exec = 1'b1;
			`RSO_OP_SPECIAL: f_is_exec = 1'b1;
			default: f_is_exec = 1'b0;
		endcase
	endfunction

	// Only the register-operand forms may send their result to the file.
	function f_writes_reg(input [2:0] op, input dest);
		case (op)
			`RSO_OP_ROTATE: f_writes_reg = dest;
			`RSO_OP_SUB_REG: f_writes_reg = dest;
			default: f_writes_reg = 1'b0;
		endcase
	endfunction

	// Both subtract forms share one adder and the same flag updates.
	function f_is_arith(input [2:0] op);
		case (op)
			`RSO_OP_SUB_REG: f_is_arith = 1'b1;
			`RSO_OP_SUB_IMM: f_is_arith = 1'b1;
			default: f_is_arith = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Operand fetch is combinational so each operation retires in one cycle.
	assign reg_read_index_o = reg_index_i; // [RULE_02] [RULE_07]
	assign special_read_index_o = special_index_i; // [RULE_05]
	assign exec_op = f_is_exec(op_code_i);
	assign to_reg = f_writes_reg(op_code_i, dest_reg_i); // [RULE_02]
	assign is_arith = f_is_arith(op_code_i);
	assign is_rotate = (op_code_i == `RSO_OP_ROTATE);
	assign is_halt = (op_code_i == `RSO_OP_HALT);
	assign add_a = (op_code_i == `RSO_OP_SUB_IMM) ? imm_data_i : reg_data_i;

	rso_adder u_adder (
		.a_i(add_a),
		.b_i(acc_q),
		.cin_i(carry_q),
		.sum_o(sum),
		.half_o(half),
		.carry_o(carry)
	); // [RULE_03] [RULE_04]

	// Selects the result of the current operation.
	always @* begin
		result = 8'h00;
		case (op_code_i)
			`RSO_OP_ROTATE: begin
				result = {carry_q, reg_data_i[7:1]}; // [RULE_01]
			end
			`RSO_OP_SUB_REG: begin
				result = sum; // [RULE_03]
			end
			`RSO_OP_SUB_IMM: begin
				result = sum; // [RULE_04]
			end
			`RSO_OP_SPECIAL: begin
				result = special_data_i; // [RULE_05]
			end
			default: begin
				result = 8'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// The write port is registered, so the register file sees a write one
	// cycle after its operation; it must forward a pending write to a read
	// of the same index when operations on one register follow each other.
	// Halt only reports itself here; stopping the core is done outside.
	always @* begin
		acc_d = acc_q;
		carry_d = carry_q;
		half_d = half_q;
		zero_d = zero_q;
		expiry_d = expiry_q;
		pdown_d = pdown_q;
		wr_d = 1'b0;
		wr_index_d = wr_index_q;
		wr_data_d = wr_data_q;
		wd_clear_d = 1'b0;
		halt_d = halt_q;
		if (op_valid_i && is_halt) begin
			wd_clear_d = 1'b1; // [RULE_06]
			expiry_d = 1'b1; // [RULE_06]
			pdown_d = 1'b0; // [RULE_06]
			halt_d = 1'b1; // [RULE_06]
		end else if (op_valid_i && exec_op) begin
			halt_d = 1'b0;
			if (to_reg) begin
				wr_d = 1'b1; // [RULE_02] [RULE_07]
				wr_index_d = reg_index_i;
				wr_data_d = result;
			end else begin
				acc_d = result; // [RULE_02] [RULE_04]
			end
			if (is_rotate) begin
				carry_d = reg_data_i[0]; // [RULE_01]
			end
			if (is_arith) begin
				carry_d = carry; // [RULE_03]
				half_d = half; // [RULE_03]
				zero_d = (sum == 8'h00); // [RULE_03]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// A low clock enable freezes every register, pulses included.
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			acc_q <= `RSO_ACC_RESET;
			carry_q <= `RSO_CARRY_RESET;
			half_q <= `RSO_HALF_RESET;
			zero_q <= `RSO_ZERO_RESET;
			expiry_q <= `RSO_EXPIRY_RESET;
			pdown_q <= `RSO_PDOWN_RESET;
			wr_q <= `RSO_PULSE_RESET;
			wr_index_q <= `RSO_WR_INDEX_RESET;
			wr_data_q <= `RSO_WR_DATA_RESET;
			wd_clear_q <= `RSO_PULSE_RESET;
			halt_q <= `RSO_HALT_RESET;
		end else if (clk_en_i) begin
			acc_q <= acc_d;
			carry_q <= carry_d;
			half_q <= half_d;
			zero_q <= zero_d;
			expiry_q <= expiry_d;
			pdown_q <= pdown_d;
			wr_q <= wr_d;
			wr_index_q <= wr_index_d;
			wr_data_q <= wr_data_d;
			wd_clear_q <= wd_clear_d;
			halt_q <= halt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs come straight from the flip-flops.
	assign working_register_o = acc_q;
	assign carry_flag_o = carry_q;
	assign half_carry_flag_o = half_q;
	assign zero_flag_o = zero_q;
	assign watchdog_expiry_flag_o = expiry_q;
	assign power_down_flag_o = pdown_q;
	assign reg_write_o = wr_q;
	assign reg_write_index_o = wr_index_q;
	assign reg_write_data_o = wr_data_q;
	assign watchdog_clear_o = wd_clear_q;
	assign halt_o = halt_q;
endmodule // rso_alu
`default_nettype wire

// File: test/rso_alu_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module rso_alu_asserts(input wire logic core_clk_i,reset_i,clk_en_i,
	op_valid_i,dest_reg_i,carry_flag_o,reg_write_o,watchdog_clear_o,
	watchdog_expiry_flag_o,power_down_flag_o,halt_o,
	input wire logic [2:0] op_code_i,input wire logic [6:0] reg_index_i,
	reg_write_index_o,input wire logic [7:0] reg_data_i,imm_data_i,
	special_data_i,working_register_o,reg_write_data_o);
wire [7:0] k=clk_en_i&&op_valid_i?8'h01<<op_code_i:8'h00;
default clocking @(posedge core_clk_i); endclocking
default disable iff (reset_i);
rot_carry_a: assert property(k[1]&&!dest_reg_i |=>
	working_register_o=={$past(carry_flag_o),$past(reg_data_i[7:1])}&&
	carry_flag_o==$past(reg_data_i[0])) else $error("rotate");
dest_select_a: assert property(k[1]||k[2] |=>
	reg_write_o==$past(dest_reg_i)&&(!reg_write_o||
	reg_write_index_o==$past(reg_index_i))) else $error("dest");
sub_reg_a: assert property(k[2]&&dest_reg_i |=>
	{carry_flag_o,reg_write_data_o}=={1'b0,$past(reg_data_i)}+
	{1'b0,~$past(working_register_o)}+$past(carry_flag_o)) else $error("sbr");
sub_imm_a: assert property(k[3] |=> !reg_write_o&&
	{carry_flag_o,working_register_o}=={1'b0,$past(imm_data_i)}+
	{1'b0,~$past(working_register_o)}+$past(carry_flag_o)) else $error("sbi");
special_read_a: assert property(k[4] |=>
	working_register_o==$past(special_data_i)&&$stable(carry_flag_o))
	else $error("special");
halt_entry_a: assert property(k[5] |=> watchdog_clear_o&&
	watchdog_expiry_flag_o&&!power_down_flag_o&&halt_o) else $error("halt");
one_cycle_a: assert property(clk_en_i&&k[5:1]==5'h00 |=>
	!reg_write_o&&!watchdog_clear_o)
	else $error("pulse");
cover property(k[2]&&dest_reg_i);
cover property(k[5]);
cover property(k[1]&&carry_flag_o);
cover property(k[6]||k[7]);
endmodule // rso_alu_asserts
`default_nettype wire

// File: test/rso_rf_model.sv
`timescale 1ns/100ps
`default_nettype none
module rso_rf_model(input wire logic clk_i,we_i,input wire logic [6:0] wi_i,
	ri_i,input wire logic [7:0] wd_i,output logic [7:0] rd_o);
logic [7:0] m [128];
initial foreach(m[i]) m[i]=8'(i*37);
// Forwards a pending write so back-to-back operations see the new value.
assign rd_o=(we_i&&wi_i==ri_i)?wd_i:m[ri_i];
always @(posedge clk_i) if(we_i) m[wi_i]<=wd_i;
endmodule // rso_rf_model
`default_nettype wire

// File: test/rso_alu_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rso_alu_tb;
logic core_clk_i=0,reset_i=1,clk_en_i=0,op_valid_i=0,dest_reg_i=0;
logic [2:0] op_code_i=0;
logic [6:0] reg_index_i=0;
logic [4:0] special_index_i=0;
logic [7:0] imm_data_i=0,special_data_i=0;
wire logic [7:0] reg_data_i,working_register_o,reg_write_data_o;
wire logic [6:0] reg_write_index_o,reg_read_index_o;
wire logic [4:0] special_read_index_o;
wire logic carry_flag_o,half_carry_flag_o,zero_flag_o,reg_write_o,halt_o,
	watchdog_expiry_flag_o,power_down_flag_o,watchdog_clear_o;
int failures=0,samples_checked=0,a=0,c=0,z=0,h=0,p=1,r,s=0,w=0;
int wi=0,hl=0,wc=0;
int rf[128];
rso_alu u_dut(.core_clk_i(core_clk_i),.reset_i(reset_i),.clk_en_i(clk_en_i),
	.op_valid_i(op_valid_i),.op_code_i(op_code_i),.reg_index_i(reg_index_i),
	.dest_reg_i(dest_reg_i),.reg_data_i(reg_data_i),.imm_data_i(imm_data_i),
	.special_index_i(special_index_i),.special_data_i(special_data_i),
	.working_register_o(working_register_o),.carry_flag_o(carry_flag_o),
	.half_carry_flag_o(half_carry_flag_o),.zero_flag_o(zero_flag_o),
	.watchdog_expiry_flag_o(watchdog_expiry_flag_o),
	.power_down_flag_o(power_down_flag_o),.reg_write_o(reg_write_o),
	.reg_write_index_o(reg_write_index_o),
	.reg_write_data_o(reg_write_data_o),
	.watchdog_clear_o(watchdog_clear_o),.halt_o(halt_o),
	.reg_read_index_o(reg_read_index_o),
	.special_read_index_o(special_read_index_o));
rso_rf_model u_rf(.clk_i(core_clk_i),.we_i(reg_write_o),.wi_i(reg_write_index_o),
	.ri_i(reg_read_index_o),.wd_i(reg_write_data_o),.rd_o(reg_data_i));
always #5 core_clk_i=~core_clk_i;
task chk(string n,logic [8:0] v,e);
	samples_checked++;
	if(v!==e) begin
		failures++;
		$display("MISMATCH %s exp %h got %h",n,e,v);
	end
endtask
task close_out;
	if(failures==0&&samples_checked>0) $display("No errors found");
	else $display("Errors were found");
	$finish;
endtask
initial begin
	void'($urandom(39));
	foreach(rf[i]) rf[i]=i*37%256;
	repeat(20) @(posedge core_clk_i);
	reset_i<=0;
	repeat(3000) begin
		@(negedge core_clk_i);
		r=rf[reg_index_i];
		if(clk_en_i) begin
			w=0;
			wc=0;
			if(op_valid_i) case(op_code_i)
			1: begin
				s=c*128+r/2;
				c=r%2;
				w=dest_reg_i;
			end
			2,3: begin
				r=op_code_i==2?r:imm_data_i;
				s=r+255-a+c;
				h=r%16+15-a%16+c>15;
				c=s>255;
				s%=256;
				z=s==0;
				w=dest_reg_i&&op_code_i==2;
			end
			4: s=special_data_i;
			5: begin
				p=0;
				wc=1;
				hl=1;
			end
			endcase
			if(op_valid_i&&op_code_i inside {[1:4]}) begin
				hl=0;
				if(w) begin
					wi=reg_index_i;
					rf[wi]=s;
				end else a=s;
			end
		end
		@(posedge core_clk_i);
		clk_en_i<=$urandom%8!=0;
		op_valid_i<=$urandom%4!=0;
		op_code_i<=$urandom%8;
		{special_index_i,dest_reg_i,reg_index_i,imm_data_i,
			special_data_i}<=$urandom;
		#1;
		chk("acc",working_register_o,a);
		chk("flg",{carry_flag_o,zero_flag_o,half_carry_flag_o,reg_write_o,
			power_down_flag_o,halt_o,watchdog_clear_o,watchdog_expiry_flag_o},
			{c[0],z[0],h[0],w[0],p[0],hl[0],wc[0],1'b1});
		chk("ridx",reg_read_index_o,reg_index_i);
		chk("sidx",special_read_index_o,special_index_i);
		if(w) chk("wdata",reg_write_data_o,s);
		if(w) chk("widx",reg_write_index_o,wi);
	end
	close_out;
end
endmodule // rso_alu_tb
bind rso_alu rso_alu_asserts u_chk(.core_clk_i(core_clk_i),.reset_i(reset_i),
	.clk_en_i(clk_en_i),.op_valid_i(op_valid_i),.dest_reg_i(dest_reg_i),
	.carry_flag_o(carry_flag_o),.reg_write_o(reg_write_o),
	.watchdog_clear_o(watchdog_clear_o),
	.watchdog_expiry_flag_o(watchdog_expiry_flag_o),
	.power_down_flag_o(power_down_flag_o),.halt_o(halt_o),
	.op_code_i(op_code_i),.reg_index_i(reg_index_i),
	.reg_write_index_o(reg_write_index_o),.reg_data_i(reg_data_i),
	.imm_data_i(imm_data_i),.special_data_i(special_data_i),
	.working_register_o(working_register_o),
	.reg_write_data_o(reg_write_data_o));
`default_nettype wire
